/* sensor_link_device.sv */
// sensor end of the programming link with its command buffer
// What this block does
// - supply at program level silences analog output
// - controller pulls pin low in the cycle it raises enable
// - supply dropped: output follows field again
// - output re-enabled after enable delay
// - eeprom write needs long store delay
// - eeprom write done: high-to-low on pin
// - after first frame, further pulses ignored
// - controller toggles enable between frames
// - supply, data pin and ground form link
// - four transaction kinds only
// - frame opens with two zero sync bits
// - direction bit then six address bits
// - read answer: ecc status and data
// - write field: low 24 bits data
// - frame closes with three check bits
// - manchester, rising is 0, msb first
// - only reads answered, never initiates
// - controller waits out the read answer
module sensor_link_device #(
  parameter int TE_CYC = slink_pkg::TE_CYC,
  parameter int TW_CYC = slink_pkg::TW_CYC,
  parameter int MAX_BIT_CYC = slink_pkg::MAX_BIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  slink_if.device link,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output slink_pkg::cmd_kind_t cmd_kind_o,
  output logic [5:0] cmd_addr_o,
  output logic [23:0] cmd_data_o,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  input wire logic [23:0] rd_data_i,
  input wire logic [1:0] rd_ecc_i,
  output logic analog_en_o,
  output logic frame_err_o
);
  localparam int TW = slink_pkg::TMR_W;
  localparam int FB = slink_pkg::FRAME_BITS;
  localparam int BW = 32;

  // elaboration check of the counter reach
  if (TE_CYC < 1 || TW_CYC < 1 || MAX_BIT_CYC < 4 ||
      TW_CYC >= 2 ** (TW - 1) || TE_CYC >= 2 ** (TW - 1) ||
      MAX_BIT_CYC >= 2 ** (TW - 2)) begin : g_bad_param
    $error("sensor_link_device: timing parameter out of range");
  end

  localparam logic [TW-1:0] TE_T = TW'(TE_CYC);
  localparam logic [TW-1:0] TWR_T = TW'(TW_CYC);
  localparam logic [TW-1:0] MAXB_T = TW'(MAX_BIT_CYC);

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_LOW, S_SYNC0, S_SYNC1, S_RX, S_PUSH, S_GAP,
    S_NV_HIGH, S_RD_WAIT, S_PRE, S_TX, S_HOLD
  } dev_state_t;

  // ****************************************************************
  // link state
  // ****************************************************************
  dev_state_t state, next_state;
  logic [TW-1:0] tmr, next_tmr;
  logic [TW-1:0] bitlen, next_bitlen;
  logic [5:0] nbits, next_nbits;
  logic [FB-1:0] sr, next_sr;
  logic half, next_half;
  logic pin_q;
  logic dev_pin, next_dev_pin;
  logic dev_oe_n, next_dev_oe_n;
  logic analog_en, next_analog_en;
  logic err, next_err;
  logic rd_ready, next_rd_ready;
  slink_pkg::cmd_kind_t kind, next_kind;
  logic rise, fall, edge_seen;
  logic [TW-1:0] early, late;
  logic [FB-1:0] frame;
  logic push;
  logic [BW-1:0] entry;

  // ****************************************************************
  // two-entry command buffer
  // ****************************************************************
  logic [1:0] bv, next_bv;
  logic [BW-1:0] bq [2];
  logic [BW-1:0] next_bq [2];
  logic pop;

  assign rise = link.pin & ~pin_q;
  assign fall = ~link.pin & pin_q;
  assign edge_seen = rise | fall;
  assign early = bitlen - (bitlen >> 2);
  assign late = bitlen + (bitlen >> 1);
  assign frame = {sr[FB-2:0], fall};
  assign pop = bv[0] & cmd_ready_i;
  // a full buffer stalls the link fsm in S_PUSH
  assign push = (state == S_PUSH) & ~bv[1];
  assign entry = {kind,
    sr[slink_pkg::ADDR_LSB +: 6], sr[slink_pkg::DATA_LSB +: 24]};

  // buffer next values: pop shifts down, push fills first free slot
  always_comb begin
    next_bv = bv;
    next_bq = bq;
    if (pop) begin
      next_bq[0] = bq[1];
      next_bv = {1'b0, bv[1]};
    end
    if (push) begin
      if (!next_bv[0]) begin
        next_bq[0] = entry;
        next_bv[0] = 1'b1;
      end else begin
        next_bq[1] = entry;
        next_bv[1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bv <= 2'h0;
      bq[0] <= '0;
      bq[1] <= '0;
    end else begin
      bv <= next_bv;
      bq <= next_bq;
    end
  end

  assign cmd_valid_o = bv[0];
  assign cmd_kind_o = slink_pkg::cmd_kind_t'(bq[0][31:30]);
  assign cmd_addr_o = bq[0][29:24];
  assign cmd_data_o = bq[0][23:0];

  // ****************************************************************
  // link fsm
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_tmr = tmr + TW'(1);
    next_bitlen = bitlen;
    next_nbits = nbits;
    next_sr = sr;
    next_half = half;
    next_dev_pin = dev_pin;
    next_dev_oe_n = dev_oe_n;
    next_analog_en = analog_en;
    next_err = 1'b0;
    next_kind = kind;
    unique case (state)
      S_IDLE: begin
        if (tmr >= TE_T) begin
          next_tmr = tmr;
          next_analog_en = 1'b1;
        end
        if (link.prog_en) begin
          next_state = S_WAIT_LOW;
          next_analog_en = 1'b0;
        end
      end
      // relies on the pin pulled low
      S_WAIT_LOW: if (!link.pin) next_state = S_SYNC0;
      S_SYNC0: begin
        next_tmr = '0;
        if (rise) next_state = S_SYNC1;
      end
      S_SYNC1: begin
        // second sync rise gives the bit time
        if (rise) begin
          next_bitlen = tmr;
          next_tmr = '0;
          next_nbits = 6'(slink_pkg::SYNC_BITS);
          next_sr = '0;
          next_state = S_RX;
        end else if (tmr > MAXB_T) begin
          next_err = 1'b1;
          next_state = S_HOLD;
        end
      end
      S_RX: begin
        if (edge_seen && tmr >= early) begin
          next_sr = frame;
          next_tmr = '0;
          next_nbits = nbits + 6'h1;
          if (nbits == 6'(FB - 1)) begin
            if (slink_pkg::crc_of(frame[39:3]) == frame[2:0]) begin
              next_state = S_PUSH;
            end else begin
              next_err = 1'b1;
              next_state = S_HOLD;
            end
            if (frame[slink_pkg::RW_POS]) begin
              next_kind = slink_pkg::CMD_READ;
            end else if (frame[38:33] == slink_pkg::ACCESS_ADDR) begin
              next_kind = slink_pkg::CMD_ACCESS;
            end else if (frame[38:33] < slink_pkg::NV_ADDR_LIMIT) begin
              next_kind = slink_pkg::CMD_NV_WRITE;
            end else begin
              next_kind = slink_pkg::CMD_VOL_WRITE;
            end
          end
        end else if (tmr > late) begin
          next_err = 1'b1;
          next_state = S_HOLD;
        end
      end
      S_PUSH: begin
        next_tmr = '0;
        if (!bv[1]) next_state = S_GAP;
      end
      // let the controller finish its last half bit
      S_GAP: begin
        if (tmr >= bitlen) begin
          next_tmr = '0;
          if (kind == slink_pkg::CMD_READ) begin
            next_state = S_RD_WAIT;
          end else if (kind == slink_pkg::CMD_NV_WRITE) begin
            next_state = S_NV_HIGH;
            next_dev_pin = 1'b1;
            next_dev_oe_n = 1'b0;
          end else begin
            next_state = S_HOLD;
          end
        end
      end
      S_NV_HIGH: begin
        if (tmr >= TWR_T) begin
          next_dev_pin = 1'b0;
          next_state = S_HOLD;
        end
      end
      S_RD_WAIT: begin
        next_tmr = '0;
        if (rd_valid_i && rd_ready) begin
          next_sr = {2'h0, 1'b1, sr[38:33], 4'h0, rd_ecc_i, rd_data_i,
            3'h0};
          next_sr[2:0] = slink_pkg::crc_of({1'b1, sr[38:33], 4'h0,
            rd_ecc_i, rd_data_i});
          next_dev_pin = 1'b0;
          next_dev_oe_n = 1'b0;
          next_state = S_PRE;
        end
      end
      // one low bit time ahead of the answer
      S_PRE: begin
        if (tmr >= bitlen) begin
          next_tmr = '0;
          next_nbits = '0;
          next_half = 1'b0;
          next_dev_pin = sr[FB-1];
          next_state = S_TX;
        end
      end
      S_TX: begin
        if (tmr >= (bitlen >> 1)) begin
          next_tmr = '0;
          if (!half) begin
            next_half = 1'b1;
            next_dev_pin = ~sr[FB-1];
          end else begin
            next_half = 1'b0;
            next_sr = {sr[FB-2:0], 1'b0};
            next_nbits = nbits + 6'h1;
            next_dev_pin = sr[FB-2];
            if (nbits == 6'(FB - 1)) begin
              next_dev_oe_n = 1'b1;
              next_state = S_HOLD;
            end
          end
        end
      end
      S_HOLD: next_tmr = '0;
    endcase
    if (state != S_IDLE && !link.prog_en) begin
      next_state = S_IDLE;
      next_tmr = '0;
      next_dev_oe_n = 1'b1;
    end
    next_rd_ready = (next_state == S_RD_WAIT);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      tmr <= TE_T;
      bitlen <= '0;
      nbits <= '0;
      sr <= '0;
      half <= 1'b0;
      pin_q <= 1'b1;
      dev_pin <= 1'b1;
      dev_oe_n <= 1'b1;
      analog_en <= 1'b1;
      err <= 1'b0;
      rd_ready <= 1'b0;
      kind <= slink_pkg::CMD_ACCESS;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      bitlen <= next_bitlen;
      nbits <= next_nbits;
      sr <= next_sr;
      half <= next_half;
      pin_q <= link.pin;
      dev_pin <= next_dev_pin;
      dev_oe_n <= next_dev_oe_n;
      analog_en <= next_analog_en;
      err <= next_err;
      rd_ready <= next_rd_ready;
      kind <= next_kind;
    end
  end

  assign link.dev_pin = dev_pin;
  assign link.dev_pin_oe_n = dev_oe_n;
  assign rd_ready_o = rd_ready;
  assign analog_en_o = analog_en;
  assign frame_err_o = err;

endmodule : sensor_link_device

/* slink_pkg.sv */
// shared constants, types and check function of the sensor programming link
package slink_pkg;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int SYNC_BITS = 2;
  localparam int ADDR_BITS = 6;
  localparam int FIELD_BITS = 30;
  localparam int CRC_BITS = 3;
  localparam int FRAME_BITS = SYNC_BITS + 1 + ADDR_BITS + FIELD_BITS + CRC_BITS;
  localparam int PAYLOAD_BITS = 24;
  localparam int ECC_BITS = 2;
  localparam int RW_POS = 39;
  localparam int ADDR_LSB = 33;
  localparam int DATA_LSB = 3;
  localparam int ECC_LSB = DATA_LSB + PAYLOAD_BITS;
  localparam int CHECKED_BITS = 1 + ADDR_BITS + FIELD_BITS;

  // address decode of the sensor's storage
  localparam logic [5:0] ACCESS_ADDR = 6'h24;
  localparam logic [5:0] NV_ADDR_LIMIT = 6'h10;

  // ****************************************************************
  // timing, clock of 200 MHz
  // ****************************************************************
  localparam int CLK_HZ = 200000000;
  localparam int CLK_MHZ = CLK_HZ / 1000000;
  localparam int TE_US = 125;
  localparam int TD_US = 500;
  localparam int TW_MS = 20;
  localparam int RATE_MIN_BPS = 250;
  localparam int RATE_MAX_BPS = 2000;
  localparam int TE_CYC = TE_US * CLK_MHZ;
  localparam int TD_CYC = TD_US * CLK_MHZ;
  localparam int TW_CYC = TW_MS * 1000 * CLK_MHZ;
  localparam int MAX_BIT_CYC = CLK_HZ / RATE_MIN_BPS;
  localparam int MIN_BIT_CYC = (CLK_HZ + RATE_MAX_BPS - 1) / RATE_MAX_BPS;
  localparam int HALF_BIT_CYC = MIN_BIT_CYC / 2;
  localparam int TMR_W = 24;

  // ****************************************************************
  // transaction kinds and frame check
  // ****************************************************************
  typedef enum logic [1:0] {
    CMD_ACCESS, CMD_NV_WRITE, CMD_VOL_WRITE, CMD_READ
  } cmd_kind_t;

  localparam logic [2:0] CRC_POLY = 3'h3;
  localparam logic [2:0] CRC_INIT = 3'h0;

  // msb-first shift over direction, address and data field
  function automatic logic [2:0] crc_of(logic [CHECKED_BITS-1:0] v);
    logic [2:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = CHECKED_BITS - 1; i >= 0; i--) begin
      fb = c[2] ^ v[i];
      c = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
    end
    return c;
  endfunction : crc_of

endpackage : slink_pkg

/* slink_if.sv */
// three-wire programming link between controller and sensor
interface slink_if;
  logic prog_en;
  logic ctl_pin;
  logic ctl_pin_oe_n;
  logic dev_pin;
  logic dev_pin_oe_n;
  logic pin;

  // resolved output pin level, pulled high when nobody drives
  assign pin = !ctl_pin_oe_n ? ctl_pin : (!dev_pin_oe_n ? dev_pin : 1'b1);

  modport device (input prog_en, input pin, output dev_pin,
    output dev_pin_oe_n);
  modport controller (output prog_en, output ctl_pin, output ctl_pin_oe_n,
    input pin);
endinterface : slink_if

/* sensor_link_controller.sv */
// controller end of the programming link
module sensor_link_controller #(
  parameter int HALF_CYC = slink_pkg::HALF_BIT_CYC,
  parameter int TE_CYC = slink_pkg::TE_CYC,
  parameter int TMO_CYC = 2 * slink_pkg::TW_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  slink_if.controller link,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire slink_pkg::cmd_kind_t req_kind_i,
  input wire logic [5:0] req_addr_i,
  input wire logic [23:0] req_data_i,
  output logic done_o,
  output logic ok_o,
  output logic [23:0] rd_data_o,
  output logic [1:0] rd_ecc_o
);
  localparam int TW = slink_pkg::TMR_W;
  localparam int FB = slink_pkg::FRAME_BITS;

  // half bit no longer than the slowest legal rate allows
  if (HALF_CYC < 2 || 2 * HALF_CYC > slink_pkg::MAX_BIT_CYC ||
      TE_CYC < 1 || TMO_CYC < 1 || TMO_CYC >= 2 ** (TW - 1) ||
      TE_CYC >= 2 ** (TW - 1)) begin : g_bad_param
    $error("sensor_link_controller: timing parameter out of range");
  end

  localparam logic [TW-1:0] HALF_T = TW'(HALF_CYC);
  localparam logic [TW-1:0] BIT_T = TW'(2 * HALF_CYC);
  localparam logic [TW-1:0] EARLY_T = TW'(3 * HALF_CYC / 2);
  localparam logic [TW-1:0] LATE_T = TW'(3 * HALF_CYC);
  localparam logic [TW-1:0] TE_T = TW'(TE_CYC);
  localparam logic [TW-1:0] TMO_T = TW'(TMO_CYC);

  typedef enum logic [2:0] {
    C_IDLE, C_LEAD, C_TX, C_NV, C_RX_LOW, C_RX_SYNC, C_RX, C_DROP
  } ctl_state_t;

  // ****************************************************************
  // controller fsm
  // ****************************************************************
  ctl_state_t state, next_state;
  logic [TW-1:0] tmr, next_tmr;
  logic [5:0] nbits, next_nbits;
  logic [FB-1:0] sr, next_sr;
  logic half, next_half;
  slink_pkg::cmd_kind_t kind, next_kind;
  logic pin_q;
  logic prog_en, next_prog_en;
  logic ctl_pin, next_ctl_pin;
  logic ctl_oe_n, next_ctl_oe_n;
  logic ready, next_ready;
  logic done, next_done;
  logic ok, next_ok;
  logic [23:0] rd_data, next_rd_data;
  logic [1:0] rd_ecc, next_rd_ecc;
  logic rise, fall;
  logic [5:0] addr;
  logic [FB-1:0] frame;

  assign rise = link.pin & ~pin_q;
  assign fall = ~link.pin & pin_q;
  assign frame = {sr[FB-2:0], fall};
  assign addr = (req_kind_i == slink_pkg::CMD_ACCESS) ?
    slink_pkg::ACCESS_ADDR : req_addr_i;

  always_comb begin
    next_state = state;
    next_tmr = tmr + TW'(1);
    next_nbits = nbits;
    next_sr = sr;
    next_half = half;
    next_kind = kind;
    next_prog_en = prog_en;
    next_ctl_pin = ctl_pin;
    next_ctl_oe_n = ctl_oe_n;
    next_done = 1'b0;
    next_ok = ok;
    next_rd_data = rd_data;
    next_rd_ecc = rd_ecc;
    unique case (state)
      C_IDLE: begin
        next_tmr = '0;
        if (req_valid_i && ready) begin
          next_sr = {2'h0, req_kind_i == slink_pkg::CMD_READ, addr,
            6'h0, req_data_i, 3'h0};
          next_sr[2:0] = slink_pkg::crc_of({
            req_kind_i == slink_pkg::CMD_READ, addr, 6'h0, req_data_i});
          next_kind = req_kind_i;
          next_prog_en = 1'b1;
          next_ctl_pin = 1'b0;
          next_ctl_oe_n = 1'b0;
          next_ok = 1'b0;
          next_state = C_LEAD;
        end
      end
      C_LEAD: begin
        if (tmr >= BIT_T) begin
          next_tmr = '0;
          next_nbits = '0;
          next_half = 1'b0;
          next_ctl_pin = sr[FB-1];
          next_state = C_TX;
        end
      end
      C_TX: begin
        if (tmr >= HALF_T) begin
          next_tmr = '0;
          if (!half) begin
            next_half = 1'b1;
            next_ctl_pin = ~sr[FB-1];
          end else begin
            next_half = 1'b0;
            next_sr = {sr[FB-2:0], 1'b0};
            next_nbits = nbits + 6'h1;
            next_ctl_pin = sr[FB-2];
            if (nbits == 6'(FB - 1)) begin
              next_ctl_oe_n = 1'b1;
              if (kind == slink_pkg::CMD_READ) begin
                next_state = C_RX_LOW;
              end else if (kind == slink_pkg::CMD_NV_WRITE) begin
                next_state = C_NV;
              end else begin
                next_ok = 1'b1;
                next_state = C_DROP;
              end
            end
          end
        end
      end
      C_NV: begin
        // wait out the store, expect a fall
        if (fall) begin
          next_ok = 1'b1;
          next_tmr = '0;
          next_state = C_DROP;
        end else if (tmr > TMO_T) begin
          next_tmr = '0;
          next_state = C_DROP;
        end
      end
      // pin left to the device until answer ends
      C_RX_LOW: begin
        if (!link.pin) next_state = C_RX_SYNC;
        if (tmr > TMO_T) begin
          next_tmr = '0;
          next_state = C_DROP;
        end
      end
      C_RX_SYNC: begin
        if (rise) begin
          next_tmr = '0;
          next_nbits = 6'h1;
          next_sr = '0;
          next_state = C_RX;
        end else if (tmr > TMO_T) begin
          next_tmr = '0;
          next_state = C_DROP;
        end
      end
      C_RX: begin
        if ((rise || fall) && tmr >= EARLY_T) begin
          next_sr = frame;
          next_tmr = '0;
          next_nbits = nbits + 6'h1;
          if (nbits == 6'(FB - 1)) begin
            next_ok = frame[slink_pkg::RW_POS] &&
              slink_pkg::crc_of(frame[39:3]) == frame[2:0];
            next_rd_data = frame[slink_pkg::DATA_LSB +: 24];
            next_rd_ecc = frame[slink_pkg::ECC_LSB +: 2];
            next_state = C_DROP;
          end
        end else if (tmr > LATE_T) begin
          next_tmr = '0;
          next_state = C_DROP;
        end
      end
      C_DROP: begin
        next_prog_en = 1'b0;
        next_ctl_oe_n = 1'b1;
        if (tmr >= TE_T) begin
          next_done = 1'b1;
          next_state = C_IDLE;
        end
      end
    endcase
    next_ready = (next_state == C_IDLE) && !(state == C_IDLE &&
      req_valid_i && ready);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= C_IDLE;
      tmr <= '0;
      nbits <= '0;
      sr <= '0;
      half <= 1'b0;
      kind <= slink_pkg::CMD_ACCESS;
      pin_q <= 1'b1;
      prog_en <= 1'b0;
      ctl_pin <= 1'b0;
      ctl_oe_n <= 1'b1;
      ready <= 1'b0;
      done <= 1'b0;
      ok <= 1'b0;
      rd_data <= '0;
      rd_ecc <= '0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      nbits <= next_nbits;
      sr <= next_sr;
      half <= next_half;
      kind <= next_kind;
      pin_q <= link.pin;
      prog_en <= next_prog_en;
      ctl_pin <= next_ctl_pin;
      ctl_oe_n <= next_ctl_oe_n;
      ready <= next_ready;
      done <= next_done;
      ok <= next_ok;
      rd_data <= next_rd_data;
      rd_ecc <= next_rd_ecc;
    end
  end

  assign link.prog_en = prog_en;
  assign link.ctl_pin = ctl_pin;
  assign link.ctl_pin_oe_n = ctl_oe_n;
  assign req_ready_o = ready;
  assign done_o = done;
  assign ok_o = ok;
  assign rd_data_o = rd_data;
  assign rd_ecc_o = rd_ecc;

endmodule : sensor_link_controller

/* slink_props.sv */
// wire checks of the programming link between both ends
module slink_props #(
  parameter int TW_CYC = 200
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic prog_en,
  input wire logic ctl_pin,
  input wire logic ctl_pin_oe_n,
  input wire logic dev_pin,
  input wire logic dev_pin_oe_n,
  input wire logic pin
);
  // ****
  // helper: device driven-high stretch
  // ****
  logic [15:0] hi_run;
  logic [15:0] next_hi_run;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a store shows as one long high stretch, data bits stay short
  always_comb begin
    next_hi_run = (!dev_pin_oe_n && dev_pin) ? hi_run + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk_i) begin
    hi_run <= rst_i ? 16'h0 : next_hi_run;
  end
  one_driver_a: assert property (ctl_pin_oe_n || dev_pin_oe_n)
    else $error("both ends drive the pin");
  dev_quiet_a: assert property (!prog_en ##1 !prog_en |-> dev_pin_oe_n)
    else $error("device drives outside program mode");
  ctl_quiet_a: assert property (!prog_en |-> ctl_pin_oe_n)
    else $error("controller drives outside program mode");
  start_low_a: assert property ($rose(prog_en) |-> !ctl_pin_oe_n && !ctl_pin)
    else $error("pin not pulled low at enable");
  sync_gap_a: assert property ($rose(prog_en) |->
    (!pin throughout ##40 1'b1) ##[1:40] $rose(pin))
    else $error("sync edge misplaced");
  ctl_half_a: assert property (!ctl_pin_oe_n && $changed(ctl_pin)
    |=> (ctl_pin_oe_n || $stable(ctl_pin))[*8])
    else $error("controller half bit too short");
  dev_half_a: assert property (!dev_pin_oe_n && $changed(dev_pin)
    |=> (dev_pin_oe_n || $stable(dev_pin))[*8])
    else $error("device half bit too short");
  drop_hold_a: assert property ($fell(prog_en) |-> (!prog_en)[*8])
    else $error("enable drop too short");
  store_time_a: assert property (!dev_pin_oe_n && !dev_pin &&
    hi_run > 16'd100 |-> hi_run >= TW_CYC)
    else $error("store ended early");
  store_end_a: assert property (hi_run < TW_CYC + 8)
    else $error("store completion edge missing");
  read_c: cover property ($fell(dev_pin_oe_n) && !dev_pin);
  store_c: cover property (!dev_pin_oe_n && !dev_pin && hi_run > 16'd100);
  drop_c: cover property ($fell(prog_en));
endmodule : slink_props

/* sensor_programming_link_tb.sv */
// self-checking bench: controller and sensor ends joined over the link
module sensor_programming_link_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, cmd_ready_i = 1'b0;
  logic rd_valid_i = 1'b0, stall = 1'b1;
  logic [5:0] req_addr_i = 6'h0, cmd_addr_o;
  logic [23:0] req_data_i = 24'h0, rd_data_i = 24'h0, rd_data_o, cmd_data_o;
  logic [1:0] rd_ecc_i = 2'h0, rd_ecc_o;
  slink_pkg::cmd_kind_t req_kind_i = slink_pkg::CMD_READ, cmd_kind_o;
  logic req_ready_o, done_o, ok_o, cmd_valid_o, rd_ready_o;
  logic analog_en_o, frame_err_o;
  int err_count = 0, checked = 0, rd_takes = 0;
  logic [31:0] cq[$];
  logic [27:0] dq[$];
  always #2.5 clk_i = ~clk_i;
  slink_if lk();
  sensor_link_controller #(.HALF_CYC(20), .TE_CYC(20), .TMO_CYC(1000))
    sensor_link_controller_i (.clk_i, .rst_i, .link(lk), .req_valid_i,
    .req_ready_o, .req_kind_i, .req_addr_i, .req_data_i, .done_o, .ok_o,
    .rd_data_o, .rd_ecc_o);
  sensor_link_device #(.TE_CYC(20), .TW_CYC(200))
    sensor_link_device_i (.clk_i, .rst_i, .link(lk), .cmd_valid_o,
    .cmd_ready_i, .cmd_kind_o, .cmd_addr_o, .cmd_data_o, .rd_valid_i,
    .rd_ready_o, .rd_data_i, .rd_ecc_i, .analog_en_o, .frame_err_o);
  // checker's default store length equals the device's 200 above
  slink_props slink_props_i (.clk_i, .rst_i,
    .prog_en(lk.prog_en), .ctl_pin(lk.ctl_pin),
    .ctl_pin_oe_n(lk.ctl_pin_oe_n), .dev_pin(lk.dev_pin),
    .dev_pin_oe_n(lk.dev_pin_oe_n), .pin(lk.pin));
  // ****
  // shared tasks
  // ****
  task automatic cmp(input string n, input logic [31:0] e, g);
    checked++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic complete_run();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // one request; expected results noted before it goes out
  task automatic send(input slink_pkg::cmd_kind_t k);
    logic [5:0] a;
    logic [23:0] d;
    a = 6'($urandom);
    d = 24'($urandom);
    if (k == slink_pkg::CMD_ACCESS) a = slink_pkg::ACCESS_ADDR;
    if (k == slink_pkg::CMD_NV_WRITE) a[5:4] = 2'h0;
    if (k == slink_pkg::CMD_VOL_WRITE) a[5:4] = 2'h1;
    req_kind_i = k;
    req_addr_i = a;
    req_data_i = d;
    rd_data_i = 24'($urandom);
    rd_ecc_i = 2'($urandom);
    cq.push_back({k, a, d});
    dq.push_back({k, rd_ecc_i, rd_data_i});
    req_valid_i = 1'b1;
    for (int n = 0; n < 99 && !req_ready_o; n++) @(negedge clk_i);
    cmp("req_ready", 1, req_ready_o);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    repeat (100) @(negedge clk_i);
    cmp("analog_on", 0, analog_en_o);
    for (int n = 0; n < 9000 && !done_o; n++) @(negedge clk_i);
    cmp("done", 1, done_o);
    repeat (30) @(negedge clk_i);
    cmp("analog_back", 1, analog_en_o);
  endtask : send
  // receiver stalls at first so both buffer entries fill
  always @(negedge clk_i) begin
    cmd_ready_i <= stall ? 1'b0 : 1'($urandom);
    rd_valid_i <= 1'($urandom);
  end
  // results are matched against the oldest note
  always @(posedge clk_i) begin
    logic [27:0] e;
    if (rd_valid_i && rd_ready_o) rd_takes++;
    if (cmd_valid_o && cmd_ready_i && cq.size() > 0)
      cmp("cmd", cq.pop_front(), {cmd_kind_o, cmd_addr_o, cmd_data_o});
    if (!rst_i) cmp("frame_err", 0, frame_err_o);
    if (done_o && dq.size() > 0) begin
      e = dq.pop_front();
      if (e[27:26] == 2'h3) cmp("rd", e[25:0], {rd_ecc_o, rd_data_o});
      cmp("rd_take", {31'h0, e[27:26] == 2'h3}, rd_takes);
      rd_takes = 0;
      cmp("ok", 1, ok_o);
    end
  end
  initial begin
    #450000;
    err_count++;
    complete_run();
  end
  initial begin
    void'($urandom(80));
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 12; i++) begin
      stall = (i < 2);
      send(slink_pkg::cmd_kind_t'(i % 4));
    end
    repeat (50) @(negedge clk_i);
    cmp("pending", 0, cq.size() + dq.size());
    complete_run();
  end
endmodule : sensor_programming_link_tb
